// File: bench/ctrl_host.sv
// Host controller model driving control words
`timescale 1ns/10ps
module ctrl_host (
  input  wire        ref_clk,    // Clock
  output reg         word_valid, // Word strobe
  output reg  [15:0] ctrl_word,  // Control word
  output reg         read_step   // Next word request
);
  initial begin
    word_valid = 1'b0;
    ctrl_word = 16'h0000;
    read_step = 1'b0;
  end
  task send(input w, input [6:0] idx, input [7:0] pay);
    begin
      @(posedge ref_clk);
      word_valid <= 1'b1;
      ctrl_word <= {w, idx, pay};
      @(posedge ref_clk);
      word_valid <= 1'b0;
      ctrl_word <= ~{w, idx, pay};
    end
  endtask
  task step;
    begin
      @(posedge ref_clk);
      read_step <= 1'b1;
      @(posedge ref_clk);
      read_step <= 1'b0;
    end
  endtask
endmodule // ctrl_host

// File: bench/dac_regs_checker.sv
// Port assertions for the control register block
`timescale 1ns/10ps
module dac_regs_checker (
  input wire        ref_clk,                // Clock
  input wire        rst,                    // Reset
  input wire        ce,                     // Clock enable
  input wire        word_valid,             // Word strobe
  input wire [15:0] ctrl_word,              // Control word
  input wire        read_valid,             // Read strobe
  input wire [15:0] read_data,              // Read word
  input wire        read_last,              // Last word
  input wire        rolloff_select,         // Roll-off
  input wire [2:0]  audio_format_field,     // Format
  input wire        auto_inc_enable,        // Auto-increment
  input wire [6:0]  read_index,             // Read index
  input wire        system_clock_output_o,  // Clock value
  input wire        system_clock_output_oe  // Clock output enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || !ce);
  sequence cfg_wr; word_valid && ctrl_word[15:8] == 8'h09; endsequence
  sequence rd_req; word_valid && ctrl_word[15]; endsequence
  a_roll_write: assert property (
    cfg_wr |-> ##2 rolloff_select == $past(ctrl_word[5], 2))
    else $error("roll-off not taken");
  a_format_write: assert property (
    cfg_wr |-> ##2 audio_format_field == $past(ctrl_word[2:0], 2))
    else $error("format not taken");
  a_clk_off: assert property (
    cfg_wr ##0 ctrl_word[3] |-> ##[1:3] !system_clock_output_oe)
    else $error("clock pin still driven");
  a_clk_on: assert property (
    cfg_wr ##0 !ctrl_word[3] |-> ##[1:3] system_clock_output_oe)
    else $error("clock pin not driven");
  a_clk_run: assert property (
    system_clock_output_oe [*3] ##0 $stable(system_clock_output_o)
    |=> $changed(system_clock_output_o))
    else $error("clock output stuck");
  a_single_read: assert property (
    rd_req ##0 !auto_inc_enable |=> read_valid && read_last)
    else $error("single read unanswered");
  a_last_index: assert property (
    read_last |-> read_valid && read_data[15:8] == {1'b1, read_index})
    else $error("last word index wrong");
  a_reserved_zero: assert property (
    read_valid |-> (read_data[14:8] != 7'h09 || read_data[7:6] == 2'b00) &&
    (read_data[14:8] != 7'h0a || read_data[7:5] == 3'b000))
    else $error("reserved bits not zero");
endmodule // dac_regs_checker
bind dac_format_filter_readback_regs dac_regs_checker dac_regs_checker_inst (.*);

// File: bench/test_dac_format_filter_readback_regs.sv
// Self-checking bench for the control register block
`timescale 1ns/10ps
module test_dac_format_filter_readback_regs;
  reg         ref_clk = 1'b0;
  reg         rst = 1'b1;
  reg         ce = 1'b1;
  wire        wv, rs, rv, rl, ro, pa, pb, pc, ai, co, oe;
  wire [15:0] cw, rd;
  wire [2:0]  af;
  wire [1:0]  dr;
  wire [6:0]  ri;
  integer     error_cnt = 0, cmp_count = 0, i, j, n;
  reg         prev;
  always #12.5 ref_clk = ~ref_clk;
  ctrl_host ctrl_host_inst (.ref_clk(ref_clk), .word_valid(wv), .ctrl_word(cw), .read_step(rs));
  dac_format_filter_readback_regs dac_format_filter_readback_regs_inst (.ref_clk(ref_clk),
    .rst(rst), .ce(ce), .word_valid(wv), .ctrl_word(cw), .read_step(rs), .read_valid(rv),
    .read_data(rd), .read_last(rl), .rolloff_select(ro), .audio_format_field(af),
    .deemphasis_rate_field(dr), .deemph_pair_a_enable(pa), .deemph_pair_b_enable(pb),
    .deemph_pair_c_enable(pc), .auto_inc_enable(ai), .read_index(ri),
    .system_clock_output_o(co), .system_clock_output_oe(oe));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task get(input [15:0] exp, input last);
    begin
      #1;
      for (i = 0; i < 4 && rv !== 1'b1; i = i + 1) @(posedge ref_clk) #1;
      chk(rv, 16'h0001);
      chk(rd, exp);
      chk(rl, last);
    end
  endtask
  task t_reset;
    begin
      chk({6'h00, ro, af, dr, pa, pb, pc, ai}, 16'h0000);
      chk(ri, 16'h0001);
      chk(oe, 16'h0001);
      ctrl_host_inst.send(1'b1, 7'h00, 8'h00);
      get(16'h8100, 1'b1);
    end
  endtask
  task t_cfg;
    begin
      ctrl_host_inst.send(1'b0, 7'h0b, 8'h09);
      for (j = 0; j < 6; j = j + 1) begin
        ctrl_host_inst.send(1'b0, 7'h09, {2'b11, j[0], 2'b00, j[2:0]});
        repeat (2) @(posedge ref_clk) #1;
        chk({ro, af}, {j[0], j[2:0]});
        ctrl_host_inst.send(1'b1, 7'h00, 8'h00);
        get({8'h89, 2'b00, j[0], 2'b00, j[2:0]}, 1'b1);
      end
    end
  endtask
  task t_hold;
    begin
      @(posedge ref_clk) ce <= 1'b0;
      ctrl_host_inst.send(1'b0, 7'h09, 8'h20);
      prev = co;
      repeat (3) @(posedge ref_clk) #1;
      chk(co, prev);
      @(posedge ref_clk) ce <= 1'b1;
      repeat (2) @(posedge ref_clk) #1;
      chk(ro, 16'h0000);
    end
  endtask
  task t_dm;
    begin
      ctrl_host_inst.send(1'b0, 7'h0b, 8'h0a);
      for (j = 0; j < 3; j = j + 1) begin
        ctrl_host_inst.send(1'b0, 7'h0a, {3'b111, j[1:0], 3'b001 << j});
        repeat (2) @(posedge ref_clk) #1;
        chk({dr, pc, pb, pa}, {j[1:0], 3'b001 << j});
        ctrl_host_inst.send(1'b1, 7'h00, 8'h00);
        get({8'h8a, 3'b000, j[1:0], 3'b001 << j}, 1'b1);
      end
    end
  endtask
  task t_clk;
    begin
      for (j = 0; j < 3; j = j + 1) begin
        ctrl_host_inst.send(1'b0, 7'h09, {3'b000, j[0], j[1], 3'b000});
        repeat (4) @(posedge ref_clk) #1;
        n = 0;
        repeat (8) begin
          prev = co;
          @(posedge ref_clk) #1;
          n = n + (co !== prev);
        end
        chk(oe, !j[1]);
        if (!j[1]) chk(n, 8 >> j[0]);
      end
    end
  endtask
  task t_auto;
    begin
      ctrl_host_inst.send(1'b0, 7'h0b, 8'h83);
      repeat (2) @(posedge ref_clk) #1;
      chk(ai, 16'h0001);
      chk(ri, 16'h0003);
      ctrl_host_inst.send(1'b1, 7'h00, 8'h00);
      for (j = 1; j < 4; j = j + 1) begin
        if (j > 1) ctrl_host_inst.step;
        get({1'b1, j[6:0], 8'h00}, j == 3);
      end
    end
  endtask
  task test_done;
    begin
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk) #1;
    t_reset;
    t_cfg;
    t_dm;
    t_clk;
    t_hold;
    t_auto;
    test_done;
  end
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    test_done;
  end
endmodule // test_dac_format_filter_readback_regs

// File: core/clock_out_gen.v
// System clock output generator with divide-by-two and tri-state enable
`timescale 1ns/10ps
`include "dac_ctrl_consts.vh"
module clock_out_gen (
  input  wire ref_clk,       // System clock input
  input  wire rst,           // Async reset, active high
  input  wire ce,            // Clock enable
  input  wire divide,        // Quarter-rate select
  input  wire disable_out,   // Output disable
  output reg  clk_o,         // Clock output value
  output reg  clk_oe         // Clock output enable
);
  reg half_r;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      half_r <= 1'b0;
      clk_o  <= 1'b0;
      clk_oe <= 1'b0;
    end else if (ce) begin
      half_r <= ~half_r;
      // Undivided toggles each edge (half input rate); divided every second edge (quarter rate)
      if (!divide || half_r)                         // [RQ4]
        clk_o <= ~clk_o;
      clk_oe <= ~disable_out;                        // [RQ5] [RQ6]
    end
  end
endmodule // clock_out_gen

// File: core/dac_ctrl_consts.vh
// Constants for the format, de-emphasis and readback control registers
`ifndef DAC_CTRL_CONSTS_VH
`define DAC_CTRL_CONSTS_VH
`define WORD_W          16
`define RW_BIT          15
`define INDEX_HI        14
`define INDEX_LO        8
`define INDEX_W         7
`define PAYLOAD_HI      7
`define PAYLOAD_LO      0
`define RW_WRITE        1'b0
`define RW_READ         1'b1
`define REG_CFG         7'h09
`define REG_DEEMPH      7'h0a
`define REG_READBACK    7'h0b
`define REG_NONE        7'h00
`define SEQ_FIRST_INDEX 7'h01
`define INDEX_STEP      7'h01
`define CFG_ROLLOFF_BIT 5
`define CFG_DIV_BIT     4
`define CFG_DIS_BIT     3
`define CFG_FORMAT_HI   2
`define CFG_FORMAT_LO   0
`define DM_RATE_HI      4
`define DM_RATE_LO      3
`define DM_C_BIT        2
`define DM_B_BIT        1
`define DM_A_BIT        0
`define RB_INC_BIT      7
`define RB_REG_HI       6
`define RB_REG_LO       0
`define CFG_MASK        8'h3f
`define DM_MASK         8'h1f
`define RB_MASK         8'hff
`define CFG_RESET       8'h00
`define DM_RESET        8'h00
`define RB_RESET        8'h01
`define READ_DATA_RESET 16'h0000
`define PAYLOAD_ZERO    8'h00
`endif

// File: core/dac_format_filter_readback_regs.v
// Control registers 9, 10 and 11: filter, clock output, format, de-emphasis, readback
//
// Contract
// RQ1 - A control word holds the read/write flag in bit 15, the index in bits 14:8, payload below.
// RQ2 - Flag 0 writes the indexed register and flag 1 reads it.
// RQ3 - The roll-off select bit picks sharp (0, default) or slow (1) filter roll-off.
// RQ4 - The clock-divide bit gives output clock at input rate (0) or half rate (1); the code gives half (0) or quarter (1) input rate.
// RQ5 - With the disable bit 0 the output clock pin is driven with the selected clock.
// RQ6 - With the disable bit 1 the output clock pin is left high impedance.
// RQ7 - The three-bit format field selects right-justified 24/20/18/16, I2S or left-justified.
// RQ8 - The two-bit rate field selects 44.1, 48 or 32 kHz de-emphasis, 11 reserved.
// RQ9 - The first pair enable turns de-emphasis on for outputs 1 and 2.
// RQ10 - The second pair enable turns de-emphasis on for outputs 3 and 4.
// RQ11 - The third pair enable turns de-emphasis on for outputs 5 and 6.
// RQ12 - The auto-increment bit enables auto-increment readback, off after reset.
// RQ13 - The read index field names the register for a single read and resets to 01h.
// RQ14 - In auto-increment read the index field is the last register returned.
// RQ15 - Reserved bits ignore writes and read as zero.
`timescale 1ns/10ps
`include "dac_ctrl_consts.vh"
module dac_format_filter_readback_regs (
  input  wire        ref_clk,                // System clock input, 40 MHz
  input  wire        rst,                    // Async reset, active high
  input  wire        ce,                     // Clock enable
  input  wire        word_valid,             // Control word strobe, one cycle
  input  wire [15:0] ctrl_word,              // Control word from the port
  input  wire        read_step,              // Port asks next auto-increment word
  output reg         read_valid,             // Readback data valid, one cycle
  output reg  [15:0] read_data,              // Readback word
  output reg         read_last,              // Final word of a read sequence
  output reg         rolloff_select,         // 1 selects slow roll-off
  output reg  [2:0]  audio_format_field,     // Serial audio format
  output reg  [1:0]  deemphasis_rate_field,  // De-emphasis sample rate
  output reg         deemph_pair_a_enable,   // De-emphasis outputs 1 and 2
  output reg         deemph_pair_b_enable,   // De-emphasis outputs 3 and 4
  output reg         deemph_pair_c_enable,   // De-emphasis outputs 5 and 6
  output reg         auto_inc_enable,        // Auto-increment readback on
  output reg  [6:0]  read_index,             // Read register index
  output wire        system_clock_output_o,  // Clock output pin value
  output wire        system_clock_output_oe  // Clock output pin enable
);
  localparam S_IDLE = 2'b01;
  localparam S_SEQ  = 2'b10;

  // Register storage, reserved bits held at zero
  reg [7:0]  filter_clock_format_control_r;
  reg [7:0]  filter_clock_format_control_nxt;
  reg [7:0]  deemphasis_control_r;
  reg [7:0]  deemphasis_control_nxt;
  reg [7:0]  readback_control_r;
  reg [7:0]  readback_control_nxt;

  // Read sequencer
  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg [6:0]  cur_idx_r;
  reg [6:0]  cur_idx_nxt;
  reg        read_valid_nxt;
  reg [15:0] read_data_nxt;
  reg        read_last_nxt;
  reg [6:0]  word_idx;
  reg [7:0]  word_payload;

  wire       rw_flag   = ctrl_word[`RW_BIT];                        // [RQ1]
  wire [6:0] w_idx     = ctrl_word[`INDEX_HI:`INDEX_LO];            // [RQ1]
  wire [7:0] w_data    = ctrl_word[`PAYLOAD_HI:`PAYLOAD_LO];        // [RQ1]
  wire       do_wr     = word_valid && (rw_flag == `RW_WRITE);      // [RQ2]
  wire       do_rd     = word_valid && (rw_flag == `RW_READ);       // [RQ2]
  wire       inc_on    = readback_control_r[`RB_INC_BIT];           // [RQ12]
  wire [6:0] last_idx  = readback_control_r[`RB_REG_HI:`RB_REG_LO]; // [RQ14]
  wire [6:0] first_idx = inc_on ? `SEQ_FIRST_INDEX : last_idx;      // [RQ13]
  // An end index at or below the start gives a single word
  wire       more_seq  = inc_on && (last_idx > first_idx);          // [RQ12]

  always @* begin
    filter_clock_format_control_nxt = filter_clock_format_control_r;
    deemphasis_control_nxt          = deemphasis_control_r;
    readback_control_nxt            = readback_control_r;
    if (do_wr) begin
      if (w_idx == `REG_CFG) begin
        filter_clock_format_control_nxt = w_data & `CFG_MASK; // [RQ15] [RQ3] [RQ4] [RQ7]
      end else if (w_idx == `REG_DEEMPH) begin
        deemphasis_control_nxt = w_data & `DM_MASK;           // [RQ15] [RQ8]
      end else if (w_idx == `REG_READBACK) begin
        readback_control_nxt = w_data & `RB_MASK;             // [RQ12] [RQ13]
      end
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      filter_clock_format_control_r <= `CFG_RESET;
      deemphasis_control_r          <= `DM_RESET;
      readback_control_r            <= `RB_RESET;               // [RQ13]
    end else if (ce) begin
      filter_clock_format_control_r <= filter_clock_format_control_nxt;
      deemphasis_control_r          <= deemphasis_control_nxt;
      readback_control_r            <= readback_control_nxt;
    end
  end

  // Index of the word answered this cycle
  always @* begin
    if (state_r == S_SEQ) begin
      word_idx = cur_idx_r;
    end else begin
      word_idx = first_idx;
    end
  end

  // Unmapped indexes read as zero
  always @* begin
    if (word_idx == `REG_CFG) begin
      word_payload = filter_clock_format_control_r;
    end else if (word_idx == `REG_DEEMPH) begin
      word_payload = deemphasis_control_r;
    end else if (word_idx == `REG_READBACK) begin
      word_payload = readback_control_r;
    end else begin
      word_payload = `PAYLOAD_ZERO;                            // [RQ15]
    end
  end

  always @* begin
    state_nxt      = state_r;
    cur_idx_nxt    = cur_idx_r;
    read_valid_nxt = 1'b0;
    read_last_nxt  = 1'b0;
    read_data_nxt  = read_data;
    case (state_r)
      S_IDLE: begin
        if (do_rd) begin
          read_valid_nxt = 1'b1;
          read_data_nxt  = {`RW_READ, word_idx, word_payload}; // [RQ2]
          if (more_seq) begin                                  // [RQ12]
            cur_idx_nxt = first_idx + `INDEX_STEP;
            state_nxt   = S_SEQ;
          end else begin
            read_last_nxt = 1'b1;                              // [RQ13]
          end
        end
      end
      S_SEQ: begin
        // Read words are ignored while a sequence runs
        if (read_step) begin
          read_valid_nxt = 1'b1;
          read_data_nxt  = {`RW_READ, word_idx, word_payload};
          cur_idx_nxt    = cur_idx_r + `INDEX_STEP;
          // End index lowered mid-sequence still stops it
          if (cur_idx_r >= last_idx) begin                     // [RQ14]
            read_last_nxt = 1'b1;
            state_nxt     = S_IDLE;
          end
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r    <= S_IDLE;
      cur_idx_r  <= `REG_NONE;
      read_valid <= 1'b0;
      read_data  <= `READ_DATA_RESET;
      read_last  <= 1'b0;
    end else if (ce) begin
      state_r    <= state_nxt;
      cur_idx_r  <= cur_idx_nxt;
      read_valid <= read_valid_nxt;
      read_data  <= read_data_nxt;
      read_last  <= read_last_nxt;
    end
  end

  // Mirrored settings, one cycle behind the registers
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rolloff_select     <= 1'b0;
      audio_format_field <= 3'h0;
    end else if (ce) begin
      rolloff_select     <= filter_clock_format_control_r[`CFG_ROLLOFF_BIT];   // [RQ3]
      audio_format_field <= filter_clock_format_control_r[`CFG_FORMAT_HI:`CFG_FORMAT_LO]; // [RQ7]
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      deemphasis_rate_field <= 2'h0;
      deemph_pair_a_enable  <= 1'b0;
      deemph_pair_b_enable  <= 1'b0;
      deemph_pair_c_enable  <= 1'b0;
    end else if (ce) begin
      deemphasis_rate_field <= deemphasis_control_r[`DM_RATE_HI:`DM_RATE_LO]; // [RQ8]
      deemph_pair_a_enable  <= deemphasis_control_r[`DM_A_BIT];               // [RQ9]
      deemph_pair_b_enable  <= deemphasis_control_r[`DM_B_BIT];               // [RQ10]
      deemph_pair_c_enable  <= deemphasis_control_r[`DM_C_BIT];               // [RQ11]
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      auto_inc_enable <= 1'b0;
      read_index      <= `SEQ_FIRST_INDEX;
    end else if (ce) begin
      auto_inc_enable <= readback_control_r[`RB_INC_BIT];             // [RQ12]
      read_index      <= readback_control_r[`RB_REG_HI:`RB_REG_LO];   // [RQ13]
    end
  end

  clock_out_gen u_clk_out (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .ce          (ce),
    .divide      (filter_clock_format_control_r[`CFG_DIV_BIT]),   // [RQ4]
    .disable_out (filter_clock_format_control_r[`CFG_DIS_BIT]),   // [RQ5] [RQ6]
    .clk_o       (system_clock_output_o),
    .clk_oe      (system_clock_output_oe)
  );
endmodule // dac_format_filter_readback_regs
